// file: logic/hpsc_pkg.sv
// package: register map, field positions, reset values and carriers of the slot block
`default_nettype none
package hpsc_pkg;
  // ************************************************
  // register selection codes
  // ************************************************
  localparam logic [7:0] CMD_CTRL_A = 8'h02; // slot a power control
  localparam logic [7:0] CMD_CTRL_B = 8'h03; // slot b power control
  localparam logic [7:0] CMD_STAT_A = 8'h04; // slot a power status
  // ************************************************
  // field positions
  // ************************************************
  localparam int CTRL_AUX_BIT = 0; // standby enable
  localparam int CTRL_MAIN_BIT = 1; // primary enable
  localparam int CTRL_GATE_BIT = 2; // override gate
  localparam int CTRL_MAINPG_BIT = 6; // primary good
  localparam int CTRL_AUXPG_BIT = 7; // standby good
  localparam int STAT_V3OC_BIT = 0; // 3.3 v overcurrent
  localparam int STAT_V12OC_BIT = 2; // 12 v overcurrent
  localparam int STAT_AUXOC_BIT = 4; // standby overcurrent
  localparam int STAT_AUXON_BIT = 5; // standby output on
  localparam int STAT_MAINON_BIT = 6; // primary outputs on
  localparam int STAT_FAULT_BIT = 7; // trouble pin asserted
  // ************************************************
  // reset values and counts
  // ************************************************
  localparam logic [7:0] CTRL_RESET = 8'h00; // control after power-up
  localparam logic [2:0] OC_RESET = 3'h0; // status flags after power-up
  localparam logic [3:0] SMB_BITS = 4'h8; // bits per byte
  localparam logic [3:0] SMB_ADDR_PREFIX = 4'h8; // upper address bits 1000
  localparam logic [1:0] STRAP_WAIT = 2'h3; // cycles before strap freezes
  // ************************************************
  // types
  // ************************************************
  typedef enum logic [2:0] {
    SMB_IDLE, SMB_ADDR, SMB_CMD, SMB_WDATA, SMB_ACK, SMB_TX, SMB_TXACK
  } hpsc_smb_e;
  // pins of one slot
  typedef struct packed {
    logic override_n;  // diagnostic force-on, low active
    logic primary_req; // hot-plug primary power request
    logic standby_req; // hot-plug standby power request
    logic aux_good;    // standby output above threshold
    logic main_good;   // primary outputs above threshold
  } hpsc_slot_pins_s;
  // writable control field
  typedef struct packed {
    logic gate; // 1 ignores the override pin
    logic main; // primary supply on
    logic aux;  // standby supply on
  } hpsc_ctrl_s;
  // overcurrent events or flags
  typedef struct packed {
    logic aux; // standby supply
    logic v12; // 12 v supply
    logic v3;  // 3.3 v supply
  } hpsc_oc_s;
endpackage
`default_nettype wire

// file: logic/hpsc_slot.sv
// one slot: control field, override gating, enables and power-good pin
`timescale 1ns/100ps
`default_nettype none
module hpsc_slot (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // register write
  input wire logic wr,
  input wire logic [7:0] wdata,
  // synchronised pins
  input wire hpsc_pkg::hpsc_slot_pins_s pins,
  // state
  output hpsc_pkg::hpsc_ctrl_s ctrl,
  output logic force_on,
  output logic good_oe,
  output logic primary_en,
  output logic standby_en
);
  import hpsc_pkg::*;
  // ************************************************
  // control field
  // ************************************************
  logic force_c; // override active this cycle
  assign force_c = !pins.override_n && !ctrl.gate;
  // only the three writable bits are stored
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl <= CTRL_RESET[2:0];
    end else if (wr) begin
      ctrl.gate <= wdata[CTRL_GATE_BIT];
      ctrl.main <= wdata[CTRL_MAIN_BIT];
      ctrl.aux <= wdata[CTRL_AUX_BIT];
    end
  end
  // ************************************************
  // outputs
  // ************************************************
  // good pin drives low only when both outputs are good and no override
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      good_oe <= 1'b0;
      force_on <= 1'b0;
      primary_en <= 1'b0;
      standby_en <= 1'b0;
    end else begin
      good_oe <= !force_c && pins.aux_good && pins.main_good;
      force_on <= force_c;
      primary_en <= ctrl.main || pins.primary_req || force_c;
      standby_en <= ctrl.aux || pins.standby_req || force_c;
    end
  end
  // ************************************************
  // checks
  // ************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  a_ctrl_write_store: assert property (wr |=> ctrl.main == $past(wdata[1])
    && ctrl.aux == $past(wdata[0])) else $error("control write lost");
  a_gate_blocks_pin: assert property (ctrl.gate |=> !force_on)
    else $error("override acted while gated");
  a_good_and_bits: assert property ((pins.override_n || ctrl.gate) |=>
    good_oe == $past(pins.aux_good && pins.main_good))
    else $error("good pin not the and of status");
  a_force_not_good: assert property ((!pins.override_n && !ctrl.gate) |=> !good_oe)
    else $error("good pin driven under override");
endmodule // hpsc_slot
`default_nettype wire

// file: logic/hpsc_slot_regs.sv
// top: byte-transfer serial slave with slot control and status registers
`timescale 1ns/100ps
`default_nettype none
module hpsc_slot_regs (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // serial bus pins
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [2:0] addr_strap,
  // slot pins
  input wire hpsc_pkg::hpsc_slot_pins_s slot_a_pins,
  input wire hpsc_pkg::hpsc_slot_pins_s slot_b_pins,
  input wire hpsc_pkg::hpsc_oc_s slot_a_oc,
  // alert suppression from the common status bit
  input wire logic alert_suppress_bit,
  // supply enables
  output logic slot_a_primary_enable,
  output logic slot_a_standby_enable,
  output logic slot_b_primary_enable,
  output logic slot_b_standby_enable,
  // open-drain power-good pins
  output logic slot_a_good_pin_out,
  output logic slot_a_good_pin_oe,
  output logic slot_b_good_pin_out,
  output logic slot_b_good_pin_oe,
  // open-drain trouble pin
  output logic slot_a_trouble_pin_out,
  output logic slot_a_trouble_pin_oe,
  // open-drain alert, low active
  output logic alert_out,
  output logic alert_oe
);
  import hpsc_pkg::*;
  // ************************************************
  // synchronisers
  // ************************************************
  logic [1:0] smb_s; // scl, sda
  hpsc_slot_pins_s pa_s; // slot a pins
  hpsc_slot_pins_s pb_s; // slot b pins
  hpsc_oc_s oc_s; // slot a overcurrent events
  logic [2:0] strap_s; // address strap
  hpsc_sync #(.W(2), .INIT(2'h3)) u_sync_smb (
    .clk(clk), .rstn(rstn), .d({scl, sda_in}), .q(smb_s));
  // override pins idle high; a zero reset value would fake an override after reset
  hpsc_sync #(.W(5), .INIT(5'h10)) u_sync_pa (
    .clk(clk), .rstn(rstn), .d(slot_a_pins), .q(pa_s));
  hpsc_sync #(.W(5), .INIT(5'h10)) u_sync_pb (
    .clk(clk), .rstn(rstn), .d(slot_b_pins), .q(pb_s));
  hpsc_sync #(.W(3)) u_sync_oc (
    .clk(clk), .rstn(rstn), .d(slot_a_oc), .q(oc_s));
  hpsc_sync #(.W(3)) u_sync_strap (
    .clk(clk), .rstn(rstn), .d(addr_strap), .q(strap_s));
  // ************************************************
  // address strap capture
  // ************************************************
  logic [2:0] strap; // frozen device address bits
  logic [1:0] strap_cnt; // cycles since reset release
  // follow the pins until the synchroniser is settled, then freeze
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      strap <= 3'h0;
      strap_cnt <= 2'h0;
    end else if (strap_cnt != STRAP_WAIT) begin
      strap <= strap_s;
      strap_cnt <= strap_cnt + 2'h1;
    end
  end
  // ************************************************
  // bus edge detection
  // ************************************************
  logic scl_d; // delayed scl
  logic sda_d; // delayed sda
  logic scl_rise; // sample point
  logic scl_fall; // drive point
  logic start_c; // start or repeated start
  logic stop_c; // stop
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= smb_s[1];
      sda_d <= smb_s[0];
    end
  end
  assign scl_rise = smb_s[1] && !scl_d;
  assign scl_fall = !smb_s[1] && scl_d;
  assign start_c = smb_s[1] && scl_d && sda_d && !smb_s[0];
  assign stop_c = smb_s[1] && scl_d && !sda_d && smb_s[0];
  // ************************************************
  // transfer engine
  // ************************************************
  hpsc_smb_e st; // engine state
  hpsc_smb_e ack_to; // state after the acknowledge bit
  logic [3:0] cnt; // bits of the current byte
  logic [7:0] sh; // receive shifter
  logic [7:0] txsh; // transmit shifter
  logic tx_more; // host acknowledged a read byte
  logic [7:0] rd_data; // selected register value
  logic byte_done; // eighth bit taken, clock now low
  assign byte_done = scl_fall && cnt == SMB_BITS;
  // address, command, data, acknowledge, read-out
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st <= SMB_IDLE;
      ack_to <= SMB_IDLE;
      cnt <= 4'h0;
      sh <= 8'h00;
      txsh <= 8'h00;
      tx_more <= 1'b0;
      sda_oe <= 1'b0;
    end else if (stop_c) begin
      st <= SMB_IDLE;
      sda_oe <= 1'b0;
    end else if (start_c) begin
      st <= SMB_ADDR;
      cnt <= 4'h0;
      sda_oe <= 1'b0;
    end else if (scl_rise) begin
      case (st)
        SMB_ADDR, SMB_CMD, SMB_WDATA: begin
          sh <= {sh[6:0], smb_s[0]};
          cnt <= cnt + 4'h1;
        end
        SMB_TX: cnt <= cnt + 4'h1;
        SMB_TXACK: tx_more <= !smb_s[0];
        default: ;
      endcase
    end else if (scl_fall) begin
      case (st)
        // own address only; read bit picks read-out or command
        SMB_ADDR: begin
          if (byte_done) begin
            cnt <= 4'h0;
            if (sh[7:1] == {SMB_ADDR_PREFIX, strap}) begin
              sda_oe <= 1'b1;
              st <= SMB_ACK;
              ack_to <= sh[0] ? SMB_TX : SMB_CMD;
            end else begin
              st <= SMB_IDLE;
            end
          end
        end
        SMB_CMD: begin
          if (byte_done) begin
            cnt <= 4'h0;
            sda_oe <= 1'b1;
            st <= SMB_ACK;
            ack_to <= SMB_WDATA;
          end
        end
        SMB_WDATA: begin
          if (byte_done) begin
            cnt <= 4'h0;
            sda_oe <= 1'b1;
            st <= SMB_ACK;
            ack_to <= SMB_IDLE;
          end
        end
        // end of acknowledge; a read drives its first bit now
        SMB_ACK: begin
          st <= ack_to;
          if (ack_to == SMB_TX) begin
            sda_oe <= !rd_data[7];
            txsh <= {rd_data[6:0], 1'b0};
          end else begin
            sda_oe <= 1'b0;
          end
        end
        SMB_TX: begin
          if (byte_done) begin
            cnt <= 4'h0;
            sda_oe <= 1'b0;
            st <= SMB_TXACK;
          end else begin
            sda_oe <= !txsh[7];
            txsh <= {txsh[6:0], 1'b0};
          end
        end
        // host ack repeats the same register, nack ends
        SMB_TXACK: begin
          if (tx_more) begin
            st <= SMB_TX;
            sda_oe <= !rd_data[7];
            txsh <= {rd_data[6:0], 1'b0};
          end else begin
            st <= SMB_IDLE;
          end
        end
        default: st <= SMB_IDLE;
      endcase
    end
  end
  assign sda_out = 1'b0;
  // ************************************************
  // pointer and write strobe
  // ************************************************
  logic [7:0] ptr; // selected register, kept for receive-byte reads
  logic wr_stb; // one-cycle register write
  logic [7:0] wr_data; // data of the write
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ptr <= 8'h00;
      wr_stb <= 1'b0;
      wr_data <= 8'h00;
    end else begin
      wr_stb <= byte_done && st == SMB_WDATA && !start_c && !stop_c;
      if (byte_done && st == SMB_CMD) begin
        ptr <= sh;
      end
      if (byte_done && st == SMB_WDATA) begin
        wr_data <= sh;
      end
    end
  end
  // ************************************************
  // slots
  // ************************************************
  hpsc_ctrl_s ctrl_a; // slot a control field
  hpsc_ctrl_s ctrl_b; // slot b control field
  logic force_a; // slot a override active
  logic wr_ctrl_a; // write to slot a control
  logic wr_ctrl_b; // write to slot b control
  logic wr_stat_a; // write to slot a status
  assign wr_ctrl_a = wr_stb && ptr == CMD_CTRL_A;
  assign wr_ctrl_b = wr_stb && ptr == CMD_CTRL_B;
  assign wr_stat_a = wr_stb && ptr == CMD_STAT_A;
  hpsc_slot u_slot_a (
    .clk(clk), .rstn(rstn), .wr(wr_ctrl_a), .wdata(wr_data), .pins(pa_s),
    .ctrl(ctrl_a), .force_on(force_a), .good_oe(slot_a_good_pin_oe),
    .primary_en(slot_a_primary_enable), .standby_en(slot_a_standby_enable));
  hpsc_slot u_slot_b (
    .clk(clk), .rstn(rstn), .wr(wr_ctrl_b), .wdata(wr_data), .pins(pb_s),
    .ctrl(ctrl_b), .force_on(), .good_oe(slot_b_good_pin_oe),
    .primary_en(slot_b_primary_enable), .standby_en(slot_b_standby_enable));
  assign slot_a_good_pin_out = 1'b0;
  assign slot_b_good_pin_out = 1'b0;
  // ************************************************
  // sticky overcurrent flags
  // ************************************************
  hpsc_oc_s oc_flag; // slot a flags
  hpsc_oc_s oc_set; // events on enabled supplies
  hpsc_oc_s oc_clr; // write-one clears
  assign oc_set = {oc_s.aux && slot_a_standby_enable,
                   oc_s.v12 && slot_a_primary_enable,
                   oc_s.v3 && slot_a_primary_enable};
  assign oc_clr = {wr_stat_a && wr_data[STAT_AUXOC_BIT],
                   wr_stat_a && wr_data[STAT_V12OC_BIT],
                   wr_stat_a && wr_data[STAT_V3OC_BIT]};
  // an event in the clearing cycle wins over the clear
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      oc_flag <= OC_RESET;
    end else begin
      oc_flag <= (oc_flag & ~oc_clr) | oc_set;
    end
  end
  // ************************************************
  // trouble indication, hot-plug pins only
  // ************************************************
  logic main_trip; // primary overcurrent under pin request
  logic aux_trip; // standby overcurrent under pin request
  // each cause holds until its own request pin goes low
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      main_trip <= 1'b0;
      aux_trip <= 1'b0;
      slot_a_trouble_pin_oe <= 1'b0;
    end else begin
      main_trip <= pa_s.primary_req && (main_trip || oc_s.v12 || oc_s.v3);
      aux_trip <= pa_s.standby_req && (aux_trip || oc_s.aux);
      slot_a_trouble_pin_oe <= (main_trip || aux_trip) && !force_a;
    end
  end
  assign slot_a_trouble_pin_out = 1'b0;
  // ************************************************
  // alert
  // ************************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      alert_oe <= 1'b0;
    end else begin
      alert_oe <= (|oc_flag) && !alert_suppress_bit;
    end
  end
  assign alert_out = 1'b0;
  // ************************************************
  // read mux
  // ************************************************
  // unlisted codes and reserved bits read zero
  always_comb begin
    rd_data = 8'h00;
    case (ptr)
      CMD_CTRL_A: begin
        rd_data[2:0] = ctrl_a;
        rd_data[CTRL_MAINPG_BIT] = pa_s.main_good;
        rd_data[CTRL_AUXPG_BIT] = pa_s.aux_good;
      end
      CMD_CTRL_B: begin
        rd_data[2:0] = ctrl_b;
        rd_data[CTRL_MAINPG_BIT] = pb_s.main_good;
        rd_data[CTRL_AUXPG_BIT] = pb_s.aux_good;
      end
      CMD_STAT_A: begin
        rd_data[STAT_FAULT_BIT] = slot_a_trouble_pin_oe;
        rd_data[STAT_MAINON_BIT] = slot_a_primary_enable;
        rd_data[STAT_AUXON_BIT] = slot_a_standby_enable;
        rd_data[STAT_AUXOC_BIT] = oc_flag.aux;
        rd_data[STAT_V12OC_BIT] = oc_flag.v12;
        rd_data[STAT_V3OC_BIT] = oc_flag.v3;
      end
      default: rd_data = 8'h00;
    endcase
  end
  // ************************************************
  // checks
  // ************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_req_low;
    !pa_s.primary_req && !pa_s.standby_req;
  endsequence
  sequence s_aux_clear;
    wr_stat_a && wr_data[STAT_AUXOC_BIT] && !oc_set.aux;
  endsequence
  a_flag_w1c_clear: assert property (s_aux_clear |=> !oc_flag.aux)
    else $error("write one did not clear flag");
  a_flag_zero_keep: assert property (oc_flag.v12 && !oc_clr.v12 |=> oc_flag.v12)
    else $error("flag lost without write one");
  a_rsvd_read_zero: assert property ((ptr == CMD_CTRL_A |-> rd_data[5:3] == 3'h0)
    and (ptr == CMD_STAT_A |-> !rd_data[3] && !rd_data[1]))
    else $error("reserved bit reads one");
  a_main_trip_hold: assert property (main_trip && pa_s.primary_req |=> main_trip)
    else $error("primary trouble cleared early");
  a_aux_trip_hold: assert property (aux_trip && pa_s.standby_req |=> aux_trip)
    else $error("standby trouble cleared early");
  a_serial_quiet: assert property (s_req_low [*2] |=> !slot_a_trouble_pin_oe)
    else $error("trouble pin active under serial control");
  a_alert_suppress: assert property (alert_suppress_bit |=> !alert_oe)
    else $error("alert driven while suppressed");
  a_alert_follows: assert property ((|oc_flag) && !alert_suppress_bit |=> alert_oe)
    else $error("alert missing for set flag");
  a_code_b_decode: assert property (wr_ctrl_b |=> ctrl_b == $past(wr_data[2:0]))
    else $error("slot b control not written");
endmodule // hpsc_slot_regs
`default_nettype wire

// file: logic/hpsc_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/100ps
`default_nettype none
module hpsc_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  // ************************************************
  // stages
  // ************************************************
  logic [W-1:0] meta; // first stage, read only by q
  generate
    if (W < 1) begin : g_bad_width
      $error("hpsc_sync width must be at least one");
    end
  endgenerate
  // both stages reset to the idle level
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta <= INIT;
      q <= INIT;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule // hpsc_sync
`default_nettype wire

// file: tb/hpsc_host.sv
// serial host model: byte write and byte read transfers
`timescale 1ns/100ps
`default_nettype none
module hpsc_host #(
  parameter logic [6:0] ADDR = 7'h40
) (
  // clock and resolved data line
  input wire logic clk,
  input wire logic sda,
  // host drives, idle released high
  output logic scl,
  output logic sda_drv
);
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // pins move on falling edges only
  task automatic hw(input int n);
    repeat (n) @(negedge clk);
  endtask
  // one bit; data moves well clear of the clock fall
  task automatic bit_io(input logic b, output logic r);
    hw(2);
    sda_drv = b;
    hw(6);
    scl = 1'b1;
    hw(4);
    r = sda;
    hw(4);
    scl = 1'b0;
  endtask
  // start or repeated start
  task automatic start();
    hw(2);
    sda_drv = 1'b1;
    hw(6);
    scl = 1'b1;
    hw(6);
    sda_drv = 1'b0;
    hw(6);
    scl = 1'b0;
  endtask
  // stop, bus left released
  task automatic stop();
    hw(2);
    sda_drv = 1'b0;
    hw(6);
    scl = 1'b1;
    hw(6);
    sda_drv = 1'b1;
    hw(6);
  endtask
  // eight bits msb first, then the acknowledge slot (host never acks)
  task automatic xfer(input logic [7:0] d, output logic [7:0] r, output logic a);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r[i]);
    end
    bit_io(1'b1, a);
  endtask
  // byte write: address, command, data
  task automatic wr(input logic [7:0] cmd, input logic [7:0] dat, output logic [2:0] acks);
    logic [7:0] r;
    start();
    xfer({ADDR, 1'b0}, r, acks[2]);
    xfer(cmd, r, acks[1]);
    xfer(dat, r, acks[0]);
    stop();
  endtask
  // byte read: command, repeated start, data with nack
  task automatic rd(input logic [7:0] cmd, output logic [7:0] dat, output logic [2:0] acks);
    logic [7:0] r;
    logic n;
    start();
    xfer({ADDR, 1'b0}, r, acks[2]);
    xfer(cmd, r, acks[1]);
    start();
    xfer({ADDR, 1'b1}, r, acks[0]);
    xfer(8'hff, dat, n);
    stop();
  endtask
  // receive byte from the last pointer; rep acks a first byte to get it twice
  task automatic rb(input logic [6:0] a7, input logic rep, output logic [7:0] dat,
                    output logic [7:0] dat2, output logic ak);
    logic [7:0] r;
    logic n;
    start();
    xfer({a7, 1'b1}, r, ak);
    dat2 = 8'hff;
    if (rep) begin
      for (int i = 7; i >= 0; i--) begin
        bit_io(1'b1, dat2[i]);
      end
      bit_io(1'b0, n);
    end
    xfer(8'hff, dat, n);
    stop();
  endtask
endmodule // hpsc_host
`default_nettype wire

// file: tb/hpsc_slot_regs_tb.sv
// testbench: slot registers through the host model against a bench model
`timescale 1ns/100ps
`default_nettype none
module hpsc_slot_regs_tb;
  import hpsc_pkg::*;
  localparam logic [2:0] STRAP = 3'h5; // board address strap
  logic clk, rstn, sda, sda_drv, sda_oe, scl, supp, ena_p, ena_s, enb_p, enb_s;
  logic goa, gob, tro, alo, trm;
  wire [4:0] zo; // constant low levels of the open-drain pins
  logic [7:0] got;
  logic [2:0] acks, om;
  logic [2:0] cm [2]; // model control fields
  hpsc_slot_pins_s pa, pb;
  hpsc_oc_s oc;
  int err_count, checked, seed;
  assign sda = sda_drv & ~sda_oe; // open-drain wired and
  hpsc_host #(.ADDR({SMB_ADDR_PREFIX, STRAP})) u_host (
    .clk(clk), .sda(sda), .scl(scl), .sda_drv(sda_drv));
  hpsc_slot_regs u_dut (
    .clk(clk), .rstn(rstn), .scl(scl), .sda_in(sda), .sda_out(zo[0]), .sda_oe(sda_oe),
    .addr_strap(STRAP), .slot_a_pins(pa), .slot_b_pins(pb), .slot_a_oc(oc),
    .alert_suppress_bit(supp), .slot_a_primary_enable(ena_p), .slot_a_standby_enable(ena_s),
    .slot_b_primary_enable(enb_p), .slot_b_standby_enable(enb_s),
    .slot_a_good_pin_out(zo[1]), .slot_a_good_pin_oe(goa),
    .slot_b_good_pin_out(zo[2]), .slot_b_good_pin_oe(gob),
    .slot_a_trouble_pin_out(zo[3]), .slot_a_trouble_pin_oe(tro),
    .alert_out(zo[4]), .alert_oe(alo));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // good pin, primary and standby enables of one slot
  function automatic logic [2:0] ex_pin(input hpsc_slot_pins_s p, input logic [2:0] c);
    logic ov;
    ov = ~p.override_n & ~c[2];
    return {p.aux_good & p.main_good & ~ov, c[1] | p.primary_req | ov, c[0] | p.standby_req | ov};
  endfunction
  function automatic logic [7:0] ex_stat();
    logic [2:0] e;
    e = ex_pin(pa, cm[0]);
    return {trm, e[1], e[0], om[2], 1'b0, om[1], 1'b0, om[0]};
  endfunction
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic pchk();
    chk({2'h0, goa, ena_p, ena_s, gob, enb_p, enb_s},
        {2'h0, ex_pin(pa, cm[0]), ex_pin(pb, cm[1])});
    chk({3'h0, zo}, 8'h00);
  endtask
  // register write through the host, model updated alongside
  task automatic wreg(input logic [7:0] c, input logic [7:0] d);
    u_host.wr(c, d, acks);
    chk({5'h0, acks}, 8'h00);
    if (c == CMD_CTRL_A) cm[0] = d[2:0];
    if (c == CMD_CTRL_B) cm[1] = d[2:0];
    if (c == CMD_STAT_A) om = om & ~{d[4], d[2], d[0]};
    repeat (5) @(negedge clk);
  endtask
  task automatic rreg(input logic [7:0] c);
    logic [7:0] e;
    e = 8'h00;
    if (c == CMD_CTRL_A) e = {pa.aux_good, pa.main_good, 3'h0, cm[0]};
    if (c == CMD_CTRL_B) e = {pb.aux_good, pb.main_good, 3'h0, cm[1]};
    if (c == CMD_STAT_A) e = ex_stat();
    u_host.rd(c, got, acks);
    chk({5'h0, acks}, 8'h00);
    chk(got, e);
  endtask
  // receive byte through the host; a refused address leaves the line released high
  task automatic rbyte(input logic [6:0] a, input logic rep, input logic [7:0] e,
                       input logic ea);
    logic [7:0] g2;
    logic ak;
    u_host.rb(a, rep, got, g2, ak);
    chk({7'h0, ak}, {7'h0, ea});
    chk(got, e);
    if (rep) chk(g2, e);
  endtask
  // overcurrent pulse on all three supplies of slot a
  task automatic trip();
    oc = 3'h7;
    repeat (6) @(negedge clk);
    oc = 3'h0;
    repeat (5) @(negedge clk);
    om = 3'h7;
  endtask
  task automatic final_report();
    if (err_count == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge clk);
    err_count++;
    final_report();
  end
  initial begin
    seed = 14465;
    err_count = 0;
    checked = 0;
    {rstn, supp, oc, om, trm} = '0;
    pa = 5'h10;
    pb = 5'h10;
    cm = '{3'h0, 3'h0};
    repeat (16) @(negedge clk);
    rstn = 1'b1;
    repeat (6) @(negedge clk);
    pchk();
    for (int c = 2; c < 8; c++) rreg(8'(c));
    repeat (6) begin
      pa[1:0] = 2'($random(seed));
      pb[1:0] = 2'($random(seed));
      wreg(CMD_CTRL_A, 8'($random(seed)));
      wreg(CMD_CTRL_B, 8'($random(seed)));
      wreg(8'h07, 8'($random(seed)));
      for (int c = 2; c < 8; c++) rreg(8'(c));
      pchk();
    end
    pa = 5'h13;
    wreg(CMD_CTRL_A, 8'h00);
    pchk();
    pa.override_n = 1'b0;
    repeat (5) @(negedge clk);
    pchk();
    rreg(CMD_STAT_A);
    wreg(CMD_CTRL_A, 8'h04);
    pchk();
    pa.override_n = 1'b1;
    wreg(CMD_CTRL_A, 8'h03);
    trip();
    chk(8'(alo), 8'h01);
    rreg(CMD_STAT_A);
    supp = 1'b1;
    repeat (3) @(negedge clk);
    chk(8'(alo), 8'h00);
    supp = 1'b0;
    wreg(CMD_STAT_A, 8'h04);
    rreg(CMD_STAT_A);
    rbyte({SMB_ADDR_PREFIX, STRAP}, 1'b1, ex_stat(), 1'b0);
    rbyte({SMB_ADDR_PREFIX, ~STRAP}, 1'b0, 8'hff, 1'b1);
    wreg(CMD_STAT_A, 8'hea);
    rreg(CMD_STAT_A);
    chk(8'(alo), 8'h01);
    wreg(CMD_STAT_A, 8'h11);
    chk(8'(alo), 8'h00);
    wreg(CMD_CTRL_A, 8'h00);
    pa.primary_req = 1'b1;
    pa.standby_req = 1'b1;
    repeat (5) @(negedge clk);
    trip();
    trm = 1'b1;
    chk(8'(tro), 8'h01);
    rreg(CMD_STAT_A);
    wreg(CMD_STAT_A, 8'h15);
    rreg(CMD_STAT_A);
    chk(8'(tro), 8'h01);
    pa.primary_req = 1'b0;
    repeat (5) @(negedge clk);
    chk(8'(tro), 8'h01);
    pa.standby_req = 1'b0;
    repeat (5) @(negedge clk);
    trm = 1'b0;
    chk(8'(tro), 8'h00);
    final_report();
  end
endmodule // hpsc_slot_regs_tb
`default_nettype wire
